// ### verilog/scm_monitor.sv
// fault supervision core of the signal conflict monitor
module scm_monitor #(
   parameter int CH = scm_pkg::CH,
   parameter int TICK_CYCLES = scm_pkg::CYC_PER_MS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // field inputs, one bit per channel
   input wire logic [CH-1:0] green,
   input wire logic [CH-1:0] yellow,
   input wire logic [CH-1:0] red,
   // control levels from the cabinet
   input wire logic red_enable,
   input wire logic special_func1,
   input wire logic special_func2,
   input wire logic output_relay_common,
   input wire logic card_present,
   input wire logic red_interface_cable,
   input wire logic watchdog,
   input wire logic ac_line_ok,
   input wire logic dc_supply_ok,
   input wire logic self_test_ok,
   // switches, jumpers and reset
   input wire logic red_fail_time_sel,
   input wire logic wdt_time_sel,
   input wire logic brownout_time_sel,
   input wire logic wdt_latch_en,
   input wire logic relay_common_invert,
   input wire logic reset_request,
   // program card straps
   input wire logic [CH-1:0] red_fail_enable,
   input wire logic [CH*CH-1:0] permit,
   // outputs
   output logic relay_energize,
   output scm_pkg::scm_ind_t ind,
   output logic [CH-1:0] chan_grn,
   output logic [CH-1:0] chan_yel,
   output logic [CH-1:0] chan_red,
   output logic [CH-1:0] chan_record
);
   localparam int NIN = 3 * CH + scm_pkg::NCTRL;
   localparam int IX = 3 * CH;
   localparam int TW = $clog2(TICK_CYCLES) + 1;
   localparam int MSW = scm_pkg::MSW;

   // millisecond tick
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic tick;
   always_comb begin
      tick = (tick_cnt == TW'(TICK_CYCLES - 1));
      next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) tick_cnt <= '0;
      else tick_cnt <= next_tick_cnt;
   end

   // red connector pins join the common pin path
   logic [NIN-1:0] pin_raw, q;
   assign pin_raw = {self_test_ok, reset_request, relay_common_invert, wdt_latch_en, brownout_time_sel,
                     wdt_time_sel, red_fail_time_sel, dc_supply_ok, ac_line_ok, watchdog,
                     red_interface_cable, card_present, output_relay_common, special_func2,
                     special_func1, red_enable, red, yellow, green};

   // synchronise and duration qualify every pin
   for (genvar i = 0; i < NIN; i++) begin : g_qual
      logic s1, s2, s3, lq, next_lq;
      logic [MSW-1:0] cnt, next_cnt;
      logic [MSW-1:0] thr;
      always_comb begin
         if (i < IX) thr = scm_pkg::FIELD_QUAL_MS;
         else if (i == IX + scm_pkg::IC_SF1 || i == IX + scm_pkg::IC_SF2) thr = scm_pkg::SF_QUAL_MS;
         else if (i == IX + scm_pkg::IC_AC)
            thr = q[IX + scm_pkg::IC_BOSEL] ? scm_pkg::BO_LONG_MS : scm_pkg::BO_SHORT_MS;
         else thr = scm_pkg::CTRL_QUAL_MS;
         next_lq = lq;
         next_cnt = '0;
         if (s2 == s3 && s3 != lq) begin
            if (cnt >= thr) next_lq = s3;
            else next_cnt = tick ? cnt + 1'b1 : cnt;
         end
      end
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            {s1, s2, s3, lq} <= 4'h0;
            cnt <= '0;
         end else begin
            {s1, s2, s3, lq} <= {pin_raw[i], s1, s2, next_lq};
            cnt <= next_cnt;
         end
      end
      assign q[i] = lq;
   end

   // static card straps
   logic [CH*CH+CH-1:0] strap1, strap2, strap3;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) {strap1, strap2, strap3} <= '0;
      else {strap1, strap2, strap3} <= {{red_fail_enable, permit}, strap1, strap2};
   end

   logic [CH-1:0] grn, yel, rd, act;
   assign grn = q[CH-1:0];
   assign yel = q[2*CH-1:CH];
   assign rd = q[3*CH-1:2*CH];
   assign act = grn | yel;

   logic q_ren, q_sf1, q_sf2, q_card, q_cable, q_wdog, q_ac, q_dc, q_wlatch, q_rst, q_self;
   logic sf_active, orc_active;
   assign q_ren = q[IX + scm_pkg::IC_REN];
   assign q_sf1 = q[IX + scm_pkg::IC_SF1];
   assign q_sf2 = q[IX + scm_pkg::IC_SF2];
   assign q_card = q[IX + scm_pkg::IC_CARD];
   assign q_cable = q[IX + scm_pkg::IC_CABLE];
   assign q_wdog = q[IX + scm_pkg::IC_WDOG];
   assign q_ac = q[IX + scm_pkg::IC_AC];
   assign q_dc = q[IX + scm_pkg::IC_DC];
   assign q_wlatch = q[IX + scm_pkg::IC_WLATCH];
   assign q_rst = q[IX + scm_pkg::IC_RST];
   assign q_self = q[IX + scm_pkg::IC_SELF];
   assign sf_active = q_sf1 | q_sf2;
   assign orc_active = q[IX + scm_pkg::IC_ORC] ^ q[IX + scm_pkg::IC_INV];

   scm_pkg::scm_state_t state, next_state;
   logic [MSW-1:0] rf_time, wd_time;
   assign rf_time = q[IX + scm_pkg::IC_RFSEL] ? scm_pkg::RF_LONG_MS : scm_pkg::RF_SHORT_MS;
   assign wd_time = q[IX + scm_pkg::IC_WDSEL] ? scm_pkg::WDT_ON_MS : scm_pkg::WDT_OFF_MS;

   logic run, chk_ok;
   assign run = (state == scm_pkg::ST_RUN);
   assign chk_ok = run & q_ren & ~orc_active;

   // red-fail counters, inhibited by special functions, red enable off, active relay common or a cleared red_fail_enable strap
   logic [CH-1:0] rf_hit;
   for (genvar c = 0; c < CH; c++) begin : g_rf
      logic [MSW-1:0] rcnt, next_rcnt;
      logic mon;
      always_comb begin
         mon = chk_ok & ~sf_active & strap3[CH*CH + c];
         next_rcnt = '0;
         if (mon && !(grn[c] | yel[c] | rd[c])) next_rcnt = (tick && rcnt < rf_time) ? rcnt + 1'b1 : rcnt;
      end
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) rcnt <= '0;
         else rcnt <= next_rcnt;
      end
      assign rf_hit[c] = mon & (rcnt >= rf_time);
   end

   // dual, clearance and conflict checks
   logic [CH-1:0] dual_hit, clr_hit, gseen, next_gseen, prev_rd, conf_ch;
   logic conf_hit;
   always_comb begin
      dual_hit = chk_ok ? ((grn & yel) | (grn & rd) | (yel & rd)) : '0;
      next_gseen = (gseen | grn) & ~yel;
      clr_hit = chk_ok ? (gseen & rd & ~prev_rd) : '0;
      conf_hit = 1'b0;
      for (int i = 0; i < CH; i++) begin
         for (int j = 0; j < CH; j++) begin
            if (i != j && act[i] && act[j] && !strap3[i*CH + j]) conf_hit = run;
         end
      end
      conf_ch = act;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gseen <= '0;
         prev_rd <= '0;
      end else begin
         gseen <= next_gseen;
         prev_rd <= rd;
      end
   end

   // watchdog timeout
   logic [MSW-1:0] wd_cnt, next_wd_cnt;
   logic wd_prev, wd_hit;
   always_comb begin
      wd_hit = run && wd_cnt >= wd_time;
      next_wd_cnt = '0;
      if (run && q_wdog == wd_prev) next_wd_cnt = (tick && !wd_hit) ? wd_cnt + 1'b1 : wd_cnt;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_cnt <= '0;
         wd_prev <= 1'b0;
      end else begin
         wd_cnt <= next_wd_cnt;
         wd_prev <= q_wdog;
      end
   end

   // fault latches and records
   scm_pkg::scm_flt_t flt, next_flt;
   logic [CH-1:0] record, next_record, snap_g, snap_y, snap_r, next_snap_g, next_snap_y, next_snap_r;
   logic rst_d, rst_pulse, power_bad;
   assign rst_pulse = q_rst & ~rst_d;
   assign power_bad = ~q_ac | (state == scm_pkg::ST_BROWN);
   always_comb begin
      next_flt = flt;
      next_record = record;
      {next_snap_g, next_snap_y, next_snap_r} = {snap_g, snap_y, snap_r};
      if (rst_pulse) begin
         next_flt = '0;
         next_record = '0;
      end
      // unlatched watchdog fault drops on power events
      if (!q_wlatch && power_bad) next_flt.wdt = 1'b0;
      // latched watchdog fault only cleared by reset above
      if (state != scm_pkg::ST_BROWN && !q_card) next_flt.card = 1'b1;
      if (state != scm_pkg::ST_BROWN && !q_cable) next_flt.cable = 1'b1;
      if (conf_hit) next_flt.conflict = 1'b1;
      if (|rf_hit) next_flt.red_fail = 1'b1;
      if (|dual_hit) next_flt.dual = 1'b1;
      if (|clr_hit) next_flt.clearance = 1'b1;
      if (wd_hit && !power_bad) next_flt.wdt = 1'b1;
      if (run && !q_dc) next_flt.dc = 1'b1;
      if (run && !q_self) next_flt.diag = 1'b1;
      // capture channels and status on fault entry
      if (run && next_flt != '0) begin
         next_record = conf_hit ? conf_ch : (rf_hit | dual_hit | clr_hit);
         {next_snap_g, next_snap_y, next_snap_r} = {grn, yel, rd};
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flt <= '0;
         record <= '0;
         {snap_g, snap_y, snap_r} <= '0;
         rst_d <= 1'b0;
      end else begin
         flt <= next_flt;
         record <= next_record;
         {snap_g, snap_y, snap_r} <= {next_snap_g, next_snap_y, next_snap_r};
         rst_d <= q_rst;
      end
   end

   // monitor state
   always_comb begin
      next_state = state;
      unique case (state)
         scm_pkg::ST_RUN: begin
            if (next_flt != '0) next_state = scm_pkg::ST_FAULT;
            else if (!q_ac) next_state = scm_pkg::ST_BROWN;
         end
         scm_pkg::ST_FAULT: begin
            if (next_flt == '0) next_state = scm_pkg::ST_RUN;
         end
         scm_pkg::ST_BROWN: begin
            if (q_ac) next_state = (next_flt != '0) ? scm_pkg::ST_FAULT : scm_pkg::ST_RUN;
         end
         default: next_state = scm_pkg::ST_BROWN;
      endcase
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) state <= scm_pkg::ST_BROWN;
      else state <= next_state;
   end

   // registered outputs
   scm_pkg::scm_ind_t next_ind;
   logic hold;
   assign hold = (state == scm_pkg::ST_FAULT);
   always_comb begin
      next_ind = '{q_ac, flt.dc, flt.wdt, flt.conflict, flt.red_fail, flt.dual, flt.clearance, flt.card | flt.cable,
                   flt.diag};
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         relay_energize <= 1'b0;
         ind <= '0;
         {chan_grn, chan_yel, chan_red, chan_record} <= '0;
      end else begin
         // relay drops whenever not running clean
         relay_energize <= (next_state == scm_pkg::ST_RUN);
         ind <= next_ind;
         {chan_grn, chan_yel, chan_red} <= hold ? {snap_g, snap_y, snap_r} : {grn, yel, rd};
         chan_record <= record;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   chk_card_fault: assert property (state != scm_pkg::ST_BROWN && !q_card |=> flt.card)
      else $error("card absence not latched");
   chk_cable_fault: assert property (state != scm_pkg::ST_BROWN && !q_cable |=> flt.cable ##1 !relay_energize)
      else $error("cable loss not latched");
   chk_record_hold: assert property (hold && !rst_pulse && next_state == scm_pkg::ST_FAULT |=> $stable(record))
      else $error("channel record changed in fault");
   chk_relay_drop: assert property ((flt != '0) |-> !relay_energize || $past(next_flt) == '0)
      else $error("relay energized with fault");
   chk_sf_inhibit: assert property ($rose(flt.red_fail) |-> $past(!sf_active))
      else $error("red fail while special function active");
   chk_wdt_unlatch: assert property (!q_wlatch && !q_ac && !wd_hit |=> !flt.wdt)
      else $error("watchdog fault kept over power loss");
   chk_wdt_latch: assert property (q_wlatch && flt.wdt && !rst_pulse |=> flt.wdt)
      else $error("latched watchdog fault lost");
   chk_led_live: assert property (state == scm_pkg::ST_RUN |=> chan_grn == $past(grn))
      else $error("channel indicator not live");
   chk_rf_time: assert property ($rose(flt.red_fail) |-> $past(|rf_hit))
      else $error("red fail without timeout");
   cov_red_fail: cover property ($rose(flt.red_fail));
   cov_conflict: cover property ($rose(flt.conflict));
   cov_wdt: cover property ($rose(flt.wdt));
   cov_brown: cover property (state == scm_pkg::ST_RUN ##1 state == scm_pkg::ST_BROWN);
endmodule : scm_monitor

// ### verilog/scm_pkg.sv
// constants and types for the signal conflict monitor fault logic
package scm_pkg;
   localparam int CH = 18;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1_000_000;
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int MSW = 11;
   // times in ms ticks
   localparam logic [10:0] RF_LONG_MS = 11'h546;
   localparam logic [10:0] RF_SHORT_MS = 11'h352;
   localparam logic [10:0] WDT_ON_MS = 11'h3E8;
   localparam logic [10:0] WDT_OFF_MS = 11'h5DC;
   localparam logic [10:0] BO_LONG_MS = 11'h190;
   localparam logic [10:0] BO_SHORT_MS = 11'h050;
   localparam logic [10:0] SF_QUAL_MS = 11'h190;
   localparam logic [10:0] FIELD_QUAL_MS = 11'h15E;
   localparam logic [10:0] CTRL_QUAL_MS = 11'h000;
   // control inputs, offsets past the 3*CH field inputs
   localparam int IC_REN = 0;
   localparam int IC_SF1 = 1;
   localparam int IC_SF2 = 2;
   localparam int IC_ORC = 3;
   localparam int IC_CARD = 4;
   localparam int IC_CABLE = 5;
   localparam int IC_WDOG = 6;
   localparam int IC_AC = 7;
   localparam int IC_DC = 8;
   localparam int IC_RFSEL = 9;
   localparam int IC_WDSEL = 10;
   localparam int IC_BOSEL = 11;
   localparam int IC_WLATCH = 12;
   localparam int IC_INV = 13;
   localparam int IC_RST = 14;
   localparam int IC_SELF = 15;
   localparam int NCTRL = 16;

   typedef struct packed {
      logic ac_power;
      logic dc_supply_fail_indicator;
      logic watchdog_fault_indicator;
      logic conflict;
      logic red_fail;
      logic dual;
      logic clearance;
      logic program_card_absent_indicator;
      logic diag_fail;
   } scm_ind_t;

   typedef struct packed {
      logic card;
      logic cable;
      logic conflict;
      logic red_fail;
      logic dual;
      logic clearance;
      logic wdt;
      logic dc;
      logic diag;
   } scm_flt_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_FAULT = 2'b01,
      ST_BROWN = 2'b10
   } scm_state_t;
endpackage : scm_pkg

// ### verif/scm_field_model.sv
// field wiring and controller heartbeat model for the monitor bench
module scm_field_model #(
   parameter int HB_CYCLES = 500
) (
   // clock
   input wire logic ref_clk,
   // scenario control
   input wire logic [scm_pkg::CH-1:0] dark,
   input wire logic [scm_pkg::CH-1:0] grn_on,
   input wire logic [scm_pkg::CH-1:0] yel_on,
   input wire logic hb_en,
   // field and controller levels
   output logic [scm_pkg::CH-1:0] green,
   output logic [scm_pkg::CH-1:0] yellow,
   output logic [scm_pkg::CH-1:0] red,
   output logic watchdog
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic hb = 1'b0;
   assign watchdog = hb;
   assign green = grn_on;
   assign yellow = yel_on;
   assign red = ~dark;
   // heartbeat stands still while stopped
   always @(posedge ref_clk) begin
      if (hb_en && cnt >= HB_CYCLES - 1) begin
         hb <= ~hb;
         cnt <= 0;
      end else if (hb_en) begin
         cnt <= cnt + 1;
      end
   end
endmodule : scm_field_model

// ### verif/scm_monitor_test.sv
// self-checking bench for the signal conflict monitor fault logic
module scm_monitor_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 5;
   localparam int CH = scm_pkg::CH;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [CH-1:0] dark = '0;
   logic [CH-1:0] grn_on = '0;
   logic [CH-1:0] yel_on = '0;
   logic orc = 1'b0;
   logic orc_inv = 1'b0;
   // channels 1 and 2 may not be active together
   wire logic [CH*CH-1:0] permit_map = ~((CH*CH)'(2) | ((CH*CH)'(1) << CH));
   logic hb_en = 1'b1;
   logic special_func1 = 1'b0;
   logic special_func2 = 1'b0;
   logic card_present = 1'b1;
   logic red_interface_cable = 1'b1;
   logic ac_line_ok = 1'b1;
   logic dc_supply_ok = 1'b1;
   logic self_test_ok = 1'b1;
   logic red_fail_time_sel = 1'b0;
   logic wdt_time_sel = 1'b0;
   logic brownout_time_sel = 1'b0;
   logic wdt_latch_en = 1'b0;
   logic reset_request = 1'b0;
   wire logic [CH-1:0] green;
   wire logic [CH-1:0] yellow;
   wire logic [CH-1:0] red;
   wire logic watchdog;
   logic relay_energize;
   scm_pkg::scm_ind_t ind;
   logic [CH-1:0] chan_grn;
   logic [CH-1:0] chan_yel;
   logic [CH-1:0] chan_red;
   logic [CH-1:0] chan_record;
   int mismatches = 0;
   int n_checks = 0;
   logic [7:0] seed = 8'h3F;
   logic [CH-1:0] mask;
   int n;

   always #(scm_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

   scm_field_model #(.HB_CYCLES(100 * TK)) i_scm_field_model (.ref_clk(ref_clk), .dark(dark), .hb_en(hb_en),
      .grn_on(grn_on), .yel_on(yel_on),
      .green(green), .yellow(yellow), .red(red), .watchdog(watchdog));

   scm_monitor #(.CH(CH), .TICK_CYCLES(TK)) i_scm_monitor (.ref_clk(ref_clk), .reset_n(reset_n), .green(green),
      .yellow(yellow), .red(red), .red_enable(1'b1), .special_func1(special_func1), .special_func2(special_func2),
      .output_relay_common(orc), .card_present(card_present), .red_interface_cable(red_interface_cable),
      .watchdog(watchdog), .ac_line_ok(ac_line_ok), .dc_supply_ok(dc_supply_ok), .self_test_ok(self_test_ok),
      .red_fail_time_sel(red_fail_time_sel), .wdt_time_sel(wdt_time_sel), .brownout_time_sel(brownout_time_sel),
      .wdt_latch_en(wdt_latch_en), .relay_common_invert(orc_inv), .reset_request(reset_request),
      .red_fail_enable({CH{1'b1}}), .permit(permit_map), .relay_energize(relay_energize), .ind(ind),
      .chan_grn(chan_grn), .chan_yel(chan_yel), .chan_red(chan_red), .chan_record(chan_record));

   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // expected red fail drop: off-qualification then the selected time
   function automatic int exp_rf(int s);
      return (int'(scm_pkg::FIELD_QUAL_MS) + (s != 0 ? 1350 : 850)) * TK;
   endfunction : exp_rf

   function automatic logic src_flag(int f);
      case (f)
         0, 1: return ind.program_card_absent_indicator;
         2: return ind.dc_supply_fail_indicator;
         default: return ind.diag_fail;
      endcase
   endfunction : src_flag

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   task automatic check_bit(input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t bit exp %h got %h", $time, exp, got);
      end
   endtask : check_bit

   task automatic check_vec(input logic [CH-1:0] exp, input logic [CH-1:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t vector exp %h got %h", $time, exp, got);
      end
   endtask : check_vec

   task automatic check_span(input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("MISMATCH at %0t cycles exp %h..%h got %h", $time, lo, hi, got);
      end
   endtask : check_span

   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic wait_relay(input logic lvl, input int max, output int cnt);
      cnt = 0;
      while (relay_energize !== lvl && cnt < max) begin
         tick(1);
         cnt++;
      end
   endtask : wait_relay

   task automatic pulse_reset;
      @(posedge ref_clk) reset_request <= 1'b1;
      tick(20);
      @(posedge ref_clk) reset_request <= 1'b0;
      tick(20);
   endtask : pulse_reset

   task automatic drive_src(input int f, input logic v);
      @(posedge ref_clk)
      case (f)
         0: card_present <= v;
         1: red_interface_cable <= v;
         2: dc_supply_ok <= v;
         default: self_test_ok <= v;
      endcase
   endtask : drive_src

   initial begin
      #950_000;
      mismatches++;
      print_verdict();
   end

   initial begin
      tick(6);
      @(posedge ref_clk) reset_n <= 1'b1;
      tick(60 * TK);
      check_bit(1'b0, relay_energize);
      wait_relay(1'b1, 50 * TK, n);
      check_span(0, 40 * TK, n);
      tick(400 * TK);
      check_vec({CH{1'b1}}, chan_red);
      check_bit(1'b1, ind.ac_power);
      for (int f = 0; f < 4; f++) begin
         drive_src(f, 1'b0);
         wait_relay(1'b0, 20, n);
         check_span(0, 19, n);
         tick(2);
         check_bit(1'b1, src_flag(f));
         pulse_reset();
         check_bit(1'b0, relay_energize);
         drive_src(f, 1'b1);
         tick(20);
         check_bit(1'b0, relay_energize);
         pulse_reset();
         check_bit(1'b1, relay_energize);
      end
      for (int s = 0; s < 2; s++) begin
         seed = lfsr(seed);
         mask = CH'(1) << (seed % CH);
         @(posedge ref_clk) red_fail_time_sel <= s[0];
         tick(10);
         @(posedge ref_clk) dark <= mask;
         wait_relay(1'b0, exp_rf(s) + 300 * TK, n);
         check_span(exp_rf(s) - 160 * TK, exp_rf(s) + 160 * TK, n);
         tick(2);
         check_bit(1'b1, ind.red_fail);
         check_vec(mask, chan_record);
         @(posedge ref_clk) dark <= '0;
         tick(400 * TK);
         check_vec(~mask, chan_red);
         pulse_reset();
         check_bit(1'b1, relay_energize);
         check_vec({CH{1'b1}}, chan_red);
      end
      @(posedge ref_clk) red_fail_time_sel <= 1'b0;
      for (int j = 0; j < 2; j++) begin
         @(posedge ref_clk) if (j == 0) special_func1 <= 1'b1; else special_func2 <= 1'b1;
         tick(600 * TK);
         @(posedge ref_clk) dark <= mask;
         tick(exp_rf(0) + 200 * TK);
         check_bit(1'b1, relay_energize);
         @(posedge ref_clk) dark <= '0;
         tick(400 * TK);
         @(posedge ref_clk) begin
            special_func1 <= 1'b0;
            special_func2 <= 1'b0;
         end
         tick(10);
      end
      // conflict between a pair without permission
      @(posedge ref_clk) begin
         grn_on <= CH'(3);
         dark <= CH'(3);
      end
      wait_relay(1'b0, 400 * TK, n);
      tick(2);
      check_bit(1'b1, ind.conflict);
      check_vec(CH'(3), chan_record);
      check_vec(CH'(3), chan_grn);
      @(posedge ref_clk) begin
         grn_on <= '0;
         dark <= '0;
      end
      tick(400 * TK);
      pulse_reset();
      check_bit(1'b1, relay_energize);
      // red after green with no yellow between
      @(posedge ref_clk) begin
         grn_on <= CH'(1);
         dark <= CH'(1);
      end
      tick(400 * TK);
      check_bit(1'b1, relay_energize);
      @(posedge ref_clk) begin
         grn_on <= '0;
         dark <= '0;
      end
      wait_relay(1'b0, 400 * TK, n);
      tick(2);
      check_bit(1'b1, ind.clearance);
      check_vec(CH'(1), chan_record);
      pulse_reset();
      // dual yellow and red, masked while relay common is active
      @(posedge ref_clk) begin
         orc <= 1'b1;
         yel_on <= CH'(4);
      end
      tick(400 * TK);
      check_bit(1'b1, relay_energize);
      @(posedge ref_clk) orc_inv <= 1'b1;
      wait_relay(1'b0, 20, n);
      check_span(0, 19, n);
      tick(2);
      check_bit(1'b1, ind.dual);
      check_vec(CH'(4), chan_yel);
      check_vec(CH'(4), chan_record);
      @(posedge ref_clk) begin
         orc <= 1'b0;
         orc_inv <= 1'b0;
         yel_on <= '0;
      end
      tick(400 * TK);
      pulse_reset();
      check_bit(1'b1, relay_energize);
      for (int l = 0; l < 2; l++) begin
         @(posedge ref_clk) begin
            wdt_latch_en <= l[0];
            wdt_time_sel <= l[0];
            brownout_time_sel <= l[0];
         end
         tick(10);
         @(watchdog);
         @(posedge ref_clk) hb_en <= 1'b0;
         wait_relay(1'b0, (l != 0 ? 1000 : 1500) * TK + 200 * TK, n);
         check_span((l != 0 ? 890 : 1390) * TK, (l != 0 ? 1110 : 1610) * TK, n);
         tick(2);
         check_bit(1'b1, ind.watchdog_fault_indicator);
         @(posedge ref_clk) begin
            hb_en <= 1'b1;
            ac_line_ok <= 1'b0;
         end
         tick(500 * TK);
         @(posedge ref_clk) ac_line_ok <= 1'b1;
         tick(600 * TK);
         check_bit(~l[0], relay_energize);
         check_bit(l[0], ind.watchdog_fault_indicator);
         pulse_reset();
         check_bit(1'b1, relay_energize);
      end
      print_verdict();
   end
endmodule : scm_monitor_test
